// ---- src/gpic_pkg.sv ----
package gpic_pkg;
  // register byte addresses (printed offsets are not all multiples of four: index * 4)
  localparam logic [7:0] IDX_INT_DMA_EN   = 8'h03;
  localparam logic [7:0] IDX_MASK_HIGH    = 8'h11;
  localparam logic [7:0] IDX_MASK_LOW     = 8'h13;
  localparam logic [7:0] IDX_AUX_CMD      = 8'h17;
  localparam logic [7:0] IDX_ADDR_CFG     = 8'h19;
  localparam logic [7:0] IDX_SPOLL_REPLY  = 8'h1b;
  localparam logic [7:0] IDX_SEC_CAPTURE  = 8'h1d;
  localparam logic [7:0] IDX_LIVE_DATA    = 8'h1f;
  localparam logic [7:0] IDX_FLAGS        = 8'h21;
  localparam logic [9:0] ADDR_INT_DMA_EN  = {IDX_INT_DMA_EN, 2'b00};
  localparam logic [9:0] ADDR_MASK_HIGH   = {IDX_MASK_HIGH, 2'b00};
  localparam logic [9:0] ADDR_MASK_LOW    = {IDX_MASK_LOW, 2'b00};
  localparam logic [9:0] ADDR_AUX_CMD     = {IDX_AUX_CMD, 2'b00};
  localparam logic [9:0] ADDR_ADDR_CFG    = {IDX_ADDR_CFG, 2'b00};
  localparam logic [9:0] ADDR_SPOLL_REPLY = {IDX_SPOLL_REPLY, 2'b00};
  localparam logic [9:0] ADDR_SEC_CAPTURE = {IDX_SEC_CAPTURE, 2'b00};
  localparam logic [9:0] ADDR_LIVE_DATA   = {IDX_LIVE_DATA, 2'b00};
  localparam logic [9:0] ADDR_FLAGS       = {IDX_FLAGS, 2'b00};

  // field positions
  localparam int BIT_IE_GLOBAL = 7;
  localparam int BIT_IE_DMA1   = 1;
  localparam int BIT_IE_DMA0   = 0;
  localparam int BIT_AUX_SET   = 7;

  // auxiliary function codes, bits 4..0
  localparam logic [4:0] AUX_CHIP_RESET = 5'h00;
  localparam logic [4:0] AUX_ACCEPT_REL = 5'h01;
  localparam logic [4:0] AUX_READY_REL  = 5'h02;
  localparam logic [4:0] AUX_HOLD_ALL   = 5'h03;
  localparam logic [4:0] AUX_HOLD_EOI   = 5'h04;
  localparam logic [4:0] AUX_NBA_FALSE  = 5'h05;
  localparam logic [4:0] AUX_TRIGGER    = 5'h06;
  localparam logic [4:0] AUX_RTL        = 5'h07;
  localparam logic [4:0] AUX_SEND_EOI   = 5'h08;
  localparam logic [4:0] AUX_LISTEN     = 5'h09;
  localparam logic [4:0] AUX_TALK       = 5'h0a;
  localparam logic [4:0] AUX_STANDBY    = 5'h0b;
  localparam logic [4:0] AUX_TAKE_ASYNC = 5'h0c;
  localparam logic [4:0] AUX_TAKE_SYNC  = 5'h0d;
  localparam logic [4:0] AUX_PPOLL      = 5'h0e;
  localparam logic [4:0] AUX_IFC        = 5'h0f;
  localparam logic [4:0] AUX_REN        = 5'h10;
  localparam logic [4:0] AUX_REQ_CTRL   = 5'h11;
  localparam logic [4:0] AUX_REL_CTRL   = 5'h12;
  localparam logic [4:0] AUX_INT_GLOBAL = 5'h13;
  localparam logic [4:0] AUX_PASS_SEC   = 5'h14;
  localparam logic [4:0] AUX_SETTLE     = 5'h15;
  localparam logic [4:0] AUX_SHADOW     = 5'h16;

  // settle delay counts in module clock cycles
  localparam logic [3:0] SETTLE_LONG    = 4'd10;
  localparam logic [3:0] SETTLE_SHORT   = 4'd6;
  // trigger pulse width: one pclk cycle
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [7:0] IFC_CHIP_RESET = 8'h00;
endpackage : gpic_pkg

// ---- src/gpic_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpic_ctrl #(
  parameter bit REDUCED = 1'b0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  dio_in,
  input  wire logic        atn_in,
  input  wire logic        sec_cmd_valid,
  input  wire logic        data_byte_rcvd,
  input  wire logic        data_byte_eoi,
  input  wire logic        tct_decoded,
  input  wire logic [5:0]  status_high,
  input  wire logic [7:0]  status_low,
  output logic             irq,
  output logic             dma0_en,
  output logic             dma1_en,
  output logic             accept_release,
  output logic             sec_valid,
  output logic             ready_release,
  output logic             holdoff_active,
  output logic             nba_clear,
  output logic             trigger_out,
  output logic             rtl_flag,
  output logic             eoi_next,
  output logic             listen_state,
  output logic             talk_state,
  output logic             atn_drive,
  output logic             sync_take,
  output logic             ppoll_active,
  output logic             ifc_drive,
  output logic             ren_drive,
  output logic             ctrl_active,
  output logic [3:0]       source_settle_delay,
  output logic             shadow_hs,
  output logic [7:0]       addr_cfg,
  output logic [7:0]       spoll_reply,
  output logic [7:0]       ppoll_reply,
  output logic [7:0]       data_out,
  output logic             data_out_load,
  output logic             chip_reset
);
  logic [7:0] dio_s1_q, dio_s2_q, atn_s;
  logic       atn_s1_q, atn_s2_q;
  logic [7:0] ie_q, mask_hi_q, mask_lo_q, sec_q;
  logic       pass_armed_q, hold_all_q, hold_eoi_q, glob_ie_q, req_ctrl_q;
  logic       wr_acc, rd_acc, aux_stb, set_op;
  logic [4:0] func;
  logic [7:0] aux_byte;
  logic [9:0] word;
  logic       trigger_held;

  // decoded as byte address; the two top address bits are not decoded
  assign word     = paddr[9:0];
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && penable && !pwrite;
  assign aux_byte = pwdata[7:0];
  assign aux_stb  = wr_acc && (word == gpic_pkg::ADDR_AUX_CMD);
  assign set_op   = aux_byte[gpic_pkg::BIT_AUX_SET];
  assign func     = aux_byte[4:0];
  assign atn_s    = {7'h00, atn_s2_q};

  // two-stage synchronisers for bus pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dio_s1_q <= 8'h00;
      dio_s2_q <= 8'h00;
      atn_s1_q <= 1'b0;
      atn_s2_q <= 1'b0;
    end else begin
      dio_s1_q <= dio_in;
      dio_s2_q <= dio_s1_q;
      atn_s1_q <= atn_in;
      atn_s2_q <= atn_s1_q;
    end
  end

  // always ready: zero wait states; unmapped accesses and reads of write-only registers error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (word)
          gpic_pkg::ADDR_SEC_CAPTURE: prdata <= pwrite ? 32'h0 : {24'h0, sec_q};
          gpic_pkg::ADDR_LIVE_DATA:   prdata <= pwrite ? 32'h0 : {24'h0, dio_s2_q};
          gpic_pkg::ADDR_FLAGS:       prdata <= {24'h0, atn_s[0], req_ctrl_q, hold_all_q,
                                                 hold_eoi_q, glob_ie_q, pass_armed_q, 2'b00};
          gpic_pkg::ADDR_INT_DMA_EN, gpic_pkg::ADDR_MASK_HIGH, gpic_pkg::ADDR_MASK_LOW,
          gpic_pkg::ADDR_AUX_CMD, gpic_pkg::ADDR_ADDR_CFG, gpic_pkg::ADDR_SPOLL_REPLY:
            pslverr <= !pwrite;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // write-only configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q        <= gpic_pkg::RESET_BYTE;
      mask_hi_q   <= gpic_pkg::RESET_BYTE;
      mask_lo_q   <= gpic_pkg::RESET_BYTE;
      addr_cfg    <= gpic_pkg::RESET_BYTE;
      spoll_reply <= gpic_pkg::RESET_BYTE;
      ppoll_reply <= gpic_pkg::RESET_BYTE;
      data_out    <= gpic_pkg::RESET_BYTE;
    end else if (chip_reset) begin
      ie_q      <= gpic_pkg::RESET_BYTE;
      mask_hi_q <= gpic_pkg::RESET_BYTE;
      mask_lo_q <= gpic_pkg::RESET_BYTE;
    end else if (wr_acc) begin
      unique case (word)
        // reduced variant keeps only bit 0
        gpic_pkg::ADDR_INT_DMA_EN:  ie_q <= REDUCED ? {7'h00, aux_byte[0]} : aux_byte;
        gpic_pkg::ADDR_MASK_HIGH:   mask_hi_q <= {2'b00, aux_byte[5:0]};
        gpic_pkg::ADDR_MASK_LOW:    mask_lo_q <= aux_byte;
        gpic_pkg::ADDR_ADDR_CFG:    addr_cfg <= aux_byte;
        gpic_pkg::ADDR_SPOLL_REPLY: spoll_reply <= aux_byte;
        gpic_pkg::ADDR_SEC_CAPTURE: ppoll_reply <= aux_byte;
        gpic_pkg::ADDR_LIVE_DATA:   data_out <= aux_byte;
        default: ;
      endcase
    end
  end

  // data-out load strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) data_out_load <= 1'b0;
    else          data_out_load <= wr_acc && (word == gpic_pkg::ADDR_LIVE_DATA);
  end

  // enables and interrupt gating: bits 6..2 are stored in the full variant only, and steer nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma0_en <= 1'b0;
      dma1_en <= 1'b0;
      irq     <= 1'b0;
    end else begin
      dma0_en <= ie_q[gpic_pkg::BIT_IE_DMA0];
      dma1_en <= ie_q[gpic_pkg::BIT_IE_DMA1];
      irq     <= ie_q[gpic_pkg::BIT_IE_GLOBAL] && glob_ie_q &&
                 (|(status_high & mask_hi_q[5:0]) || |(status_low & mask_lo_q));
    end
  end

  // secondary capture: armed by pass-through, caught from synced lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q        <= gpic_pkg::RESET_BYTE;
      pass_armed_q <= 1'b0;
    end else if (chip_reset) begin
      pass_armed_q <= 1'b0;
    end else if (aux_stb && func == gpic_pkg::AUX_PASS_SEC) begin
      pass_armed_q <= 1'b1;
    end else if (pass_armed_q && sec_cmd_valid) begin
      sec_q        <= dio_s2_q;
      pass_armed_q <= 1'b0;
    end
  end

  // one-cycle command strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept_release <= 1'b0;
      sec_valid      <= 1'b0;
      ready_release  <= 1'b0;
      nba_clear      <= 1'b0;
    end else begin
      accept_release <= aux_stb && func == gpic_pkg::AUX_ACCEPT_REL;
      sec_valid      <= aux_stb && func == gpic_pkg::AUX_ACCEPT_REL && set_op;
      ready_release  <= aux_stb && func == gpic_pkg::AUX_READY_REL;
      nba_clear    <= aux_stb && func == gpic_pkg::AUX_NBA_FALSE;
    end
  end

  // chip reset: set by 128, cleared by 0; held as a level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) chip_reset <= 1'b0;
    else if (aux_stb && func == gpic_pkg::AUX_CHIP_RESET) chip_reset <= set_op;
  end

  // holdoff modes and resulting holdoff
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_all_q     <= 1'b0;
      hold_eoi_q     <= 1'b0;
      holdoff_active <= 1'b0;
    end else if (chip_reset) begin
      hold_all_q     <= 1'b0;
      hold_eoi_q     <= 1'b0;
      holdoff_active <= 1'b0;
    end else begin
      if (aux_stb && func == gpic_pkg::AUX_HOLD_ALL) hold_all_q <= set_op;
      if (aux_stb && func == gpic_pkg::AUX_HOLD_EOI) hold_eoi_q <= set_op;
      // a new byte wins over a release in the same cycle
      if (data_byte_rcvd && (hold_all_q || (hold_eoi_q && data_byte_eoi)))
        holdoff_active <= 1'b1;
      else if (aux_stb && func == gpic_pkg::AUX_READY_REL)
        holdoff_active <= 1'b0;
    end
  end

  // trigger: 134 holds it; 6 drops it if held, else pulses one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) trigger_out <= 1'b0;
    else if (aux_stb && func == gpic_pkg::AUX_TRIGGER)
      trigger_out <= set_op ? 1'b1 : !trigger_out;
    else if (!trigger_held) trigger_out <= 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) trigger_held <= 1'b0;
    else if (aux_stb && func == gpic_pkg::AUX_TRIGGER) trigger_held <= set_op;
  end

  // persistent flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtl_flag     <= 1'b0;
      listen_state <= 1'b0;
      talk_state   <= 1'b0;
      ppoll_active <= 1'b0;
      ifc_drive    <= 1'b0;
      ren_drive    <= 1'b0;
      glob_ie_q    <= 1'b0;
      shadow_hs    <= 1'b0;
      source_settle_delay <= gpic_pkg::SETTLE_LONG;
    end else if (chip_reset) begin
      listen_state <= 1'b0;
      talk_state   <= 1'b0;
      ppoll_active <= 1'b0;
      ifc_drive    <= 1'b0;
    end else if (aux_stb) begin
      unique case (func)
        gpic_pkg::AUX_RTL:        rtl_flag <= set_op;
        gpic_pkg::AUX_LISTEN: begin
          listen_state <= set_op;
          if (set_op) talk_state <= 1'b0;
        end
        gpic_pkg::AUX_TALK: begin
          talk_state <= set_op;
          if (set_op) listen_state <= 1'b0;
        end
        gpic_pkg::AUX_PPOLL:      ppoll_active <= set_op;
        gpic_pkg::AUX_IFC:        ifc_drive <= set_op;
        gpic_pkg::AUX_REN:        ren_drive <= set_op;
        gpic_pkg::AUX_INT_GLOBAL: glob_ie_q <= !set_op;
        gpic_pkg::AUX_SHADOW:     shadow_hs <= set_op;
        gpic_pkg::AUX_SETTLE:
          source_settle_delay <= set_op ? gpic_pkg::SETTLE_SHORT : gpic_pkg::SETTLE_LONG;
        default: ;
      endcase
    end
  end

  // send EOI with the next outgoing byte, consumed by the data-out load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) eoi_next <= 1'b0;
    else if (aux_stb && func == gpic_pkg::AUX_SEND_EOI) eoi_next <= 1'b1;
    else if (data_out_load) eoi_next <= 1'b0;
  end

  // controller: ATN ownership and control pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      atn_drive   <= 1'b0;
      sync_take   <= 1'b0;
      ctrl_active <= 1'b0;
      req_ctrl_q  <= 1'b0;
    end else if (chip_reset) begin
      atn_drive   <= 1'b0;
      sync_take   <= 1'b0;
      ctrl_active <= 1'b0;
      req_ctrl_q  <= 1'b0;
    end else if (aux_stb) begin
      unique case (func)
        gpic_pkg::AUX_STANDBY:    atn_drive <= 1'b0;
        gpic_pkg::AUX_TAKE_ASYNC: begin
          atn_drive <= 1'b1;
          sync_take <= 1'b0;
        end
        gpic_pkg::AUX_TAKE_SYNC: begin
          atn_drive <= 1'b1;
          sync_take <= 1'b1;
        end
        gpic_pkg::AUX_REQ_CTRL:   req_ctrl_q <= tct_decoded;
        gpic_pkg::AUX_REL_CTRL: begin
          atn_drive   <= 1'b0;
          ctrl_active <= 1'b0;
        end
        default: ;
      endcase
    end else if (req_ctrl_q && !atn_s2_q) begin
      // wait for the old controller to drop ATN, then take over
      req_ctrl_q  <= 1'b0;
      ctrl_active <= 1'b1;
    end
  end
endmodule : gpic_ctrl
`default_nettype wire

// ---- sim/gpic_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpic_props #(
  parameter bit REDUCED = 1'b0
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        irq,
  input wire logic        dma0_en,
  input wire logic        dma1_en,
  input wire logic        accept_release,
  input wire logic        sec_valid,
  input wire logic        ready_release,
  input wire logic        trigger_out,
  input wire logic        rtl_flag,
  input wire logic        listen_state,
  input wire logic        talk_state,
  input wire logic [3:0]  source_settle_delay,
  input wire logic        chip_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed writes; while chip reset holds, aux commands other than chip reset, the strobes, trigger and send EOI are void
  logic       wr;
  logic       wa;
  logic       we;
  logic [4:0] fn;
  assign wr = psel && penable && pready && pwrite;
  assign wa = wr && !chip_reset && paddr == {2'b00, gpic_pkg::ADDR_AUX_CMD};
  assign we = wr && !chip_reset && paddr == {2'b00, gpic_pkg::ADDR_INT_DMA_EN};
  assign fn = pwdata[4:0];
  // two cycles leave room for one extra register stage behind the enable byte
  a_dma_enable: assert property (we |-> ##2 dma0_en == $past(pwdata[0], 2) &&
    dma1_en == (!REDUCED && $past(pwdata[1], 2))) else $error("dma enables do not follow the enable write");
  a_irq_gate: assert property (we && !REDUCED && !pwdata[7] |-> ##2 !irq)
    else $error("irq raised with enable bit 7 clear");
  a_irq_global: assert property (wa && pwdata[7] && fn == gpic_pkg::AUX_INT_GLOBAL |-> ##2 !irq)
    else $error("irq raised after global disable");
  a_accept_pulse: assert property (wa && fn == gpic_pkg::AUX_ACCEPT_REL
    |=> accept_release && (!sec_valid || $past(pwdata[7]))) else $error("accept release strobe wrong");
  a_ready_pulse: assert property (wa && fn == gpic_pkg::AUX_READY_REL
    |=> ready_release ##1 !ready_release) else $error("ready release is not a single strobe");
  a_trig_hold: assert property (wa && pwdata[7] && fn == gpic_pkg::AUX_TRIGGER |=> trigger_out [*2])
    else $error("trigger not held");
  a_rtl_flag: assert property (wa && fn == gpic_pkg::AUX_RTL |=> rtl_flag == $past(pwdata[7]))
    else $error("return to local flag wrong");
  a_talk_listen: assert property (wa && pwdata[7] && (fn == gpic_pkg::AUX_LISTEN || fn == gpic_pkg::AUX_TALK)
    |=> listen_state != talk_state && talk_state == $past(fn[1])) else $error("talk listen exclusion broken");
  a_settle_code: assert property (wa && fn == gpic_pkg::AUX_SETTLE |=> source_settle_delay ==
    ($past(pwdata[7]) ? gpic_pkg::SETTLE_SHORT : gpic_pkg::SETTLE_LONG)) else $error("settle delay wrong");
  a_chip_reset: assert property (wr && paddr == {2'b00, gpic_pkg::ADDR_AUX_CMD} && fn == gpic_pkg::AUX_CHIP_RESET
    |=> chip_reset == $past(pwdata[7])) else $error("chip reset does not follow set bit");
endmodule : gpic_props
bind gpic_ctrl gpic_props #(.REDUCED(REDUCED)) i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .irq, .dma0_en, .dma1_en, .accept_release, .sec_valid, .ready_release, .trigger_out, .rtl_flag,
  .listen_state, .talk_state, .source_settle_delay, .chip_reset);
`default_nettype wire

// ---- sim/gpic_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpic_bus_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] drv_byte,
  input  wire logic       drv_en,
  input  wire logic       sec_req,
  input  wire logic       byte_req,
  input  wire logic       eoi_req,
  input  wire logic       tct_req,
  input  wire logic       ext_atn,
  input  wire logic       atn_drive,
  output logic      [7:0] dio_in,
  output logic            atn_in,
  output logic            sec_cmd_valid,
  output logic            data_byte_rcvd,
  output logic            data_byte_eoi,
  output logic            tct_decoded
);
  logic [7:0] last_q;
  // remember the last byte put on the data lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) last_q <= 8'h00;
    else if (drv_en) last_q <= drv_byte;
  end
  // released lines show the inverse so a stale byte can never pass for live data
  assign dio_in = drv_en ? drv_byte : ~last_q;
  // atn is wired: true while either controller asserts it
  assign atn_in = atn_drive | ext_atn;
  // bus events arrive one cycle after they are requested
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {sec_cmd_valid, data_byte_rcvd, data_byte_eoi, tct_decoded} <= 4'h0;
    else {sec_cmd_valid, data_byte_rcvd, data_byte_eoi, tct_decoded} <= {sec_req, byte_req, byte_req & eoi_req, tct_req};
  end
endmodule : gpic_bus_model
`default_nettype wire

// ---- sim/tb_ieee488_interface_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ieee488_interface_control;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, irq, dma0_en, dma1_en, accept_release, sec_valid, ready_release, holdoff_active;
  logic        nba_clear, trigger_out, rtl_flag, eoi_next, listen_state, talk_state, atn_drive, sync_take;
  logic        ppoll_active, ifc_drive, ren_drive, ctrl_active, shadow_hs, data_out_load, chip_reset;
  logic        atn_in, sec_cmd_valid, data_byte_rcvd, data_byte_eoi, tct_decoded;
  logic        drv_en = 1'b0, sec_req = 1'b0, byte_req = 1'b0, eoi_req = 1'b0, tct_req = 1'b0, ext_atn = 1'b0;
  logic [3:0]  source_settle_delay;
  logic [7:0]  addr_cfg, spoll_reply, ppoll_reply, data_out, dio_in, drv_byte = 8'h00, status_low = 8'h00;
  logic [5:0]  status_high = 6'h00;
  int          fails = 0, n_tests = 0, n_ready = 0, n_nba = 0;
  logic [7:0]  cmd [20] = '{8'h86, 8'h06, 8'he7, 8'h07, 8'h89, 8'h8a, 8'h89, 8'h09, 8'h8a, 8'h0a,
                            8'h8e, 8'h0e, 8'h8f, 8'h0f, 8'h90, 8'h10, 8'h8c, 8'h0b, 8'h8d, 8'h8b};
  logic [7:0]  exp [20] = '{8'h80, 8'h00, 8'h40, 8'h00, 8'h20, 8'h10, 8'h20, 8'h00, 8'h10, 8'h00,
                            8'h08, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
  logic [7:0]  hcmd [4] = '{8'h83, 8'h84, 8'h03, 8'h04};
  logic [7:0]  hexp [4] = '{8'h20, 8'h30, 8'h10, 8'h00};
  wire  [7:0]  obs = {trigger_out, rtl_flag, listen_state, talk_state, ppoll_active, ifc_drive, ren_drive, atn_drive};
  always #5 pclk = ~pclk;
  // count strobes so each command must give exactly one
  always @(posedge pclk) begin
    if (ready_release === 1'b1) n_ready++;
    if (nba_clear === 1'b1) n_nba++;
  end
  gpic_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dio_in,
    .atn_in, .sec_cmd_valid, .data_byte_rcvd, .data_byte_eoi, .tct_decoded, .status_high, .status_low, .irq,
    .dma0_en, .dma1_en, .accept_release, .sec_valid, .ready_release, .holdoff_active, .nba_clear, .trigger_out,
    .rtl_flag, .eoi_next, .listen_state, .talk_state, .atn_drive, .sync_take, .ppoll_active, .ifc_drive,
    .ren_drive, .ctrl_active, .source_settle_delay, .shadow_hs, .addr_cfg, .spoll_reply, .ppoll_reply,
    .data_out, .data_out_load, .chip_reset);
  gpic_bus_model i_bus (.pclk, .presetn, .drv_byte, .drv_en, .sec_req, .byte_req, .eoi_req, .tct_req, .ext_atn,
    .atn_drive, .dio_in, .atn_in, .sec_cmd_valid, .data_byte_rcvd, .data_byte_eoi, .tct_decoded);
  task automatic test_done();
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; the answer is taken at the rising edge where pready is seen high
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, a};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      $display("BAD pready expected 1 seen %b", pready);
      test_done();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic aux(input logic [7:0] c);
    apb(1'b1, gpic_pkg::ADDR_AUX_CMD, c);
    repeat (2) @(posedge pclk);
    #1;
  endtask : aux
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("settle", 32'd10, 32'(source_settle_delay));
    for (int i = 0; i < 20; i++) begin
      aux(cmd[i]);
      chk("aux flags", 32'(exp[i]), 32'(obs));
    end
    for (int i = 0; i < 4; i++) begin
      aux(hcmd[i]);
      apb(1'b0, gpic_pkg::ADDR_FLAGS, 8'h00);
      chk("holdoff", 32'(hexp[i]), rd & 32'h30);
    end
    aux(8'h88);
    chk("eoi next", 32'h1, 32'(eoi_next));
    aux(8'h95);
    chk("settle", 32'd6, 32'(source_settle_delay));
    aux(8'h15);
    chk("settle", 32'd10, 32'(source_settle_delay));
    $display("test aux commands done");
    foreach (cmd[i]) if (i < 4) aux(8'h02 + (i[0] ? 8'h80 : 8'h00) + (i[1] ? 8'h03 : 8'h00));
    chk("ready count", 32'd2, 32'(n_ready));
    chk("nba count", 32'd2, 32'(n_nba));
    aux(8'h01);
    $display("test strobes done");
    aux(8'h14);
    drv_byte <= 8'h6b;
    drv_en <= 1'b1;
    // let the byte pass the two synchroniser stages before the command flag
    repeat (2) @(posedge pclk);
    sec_req <= 1'b1;
    @(posedge pclk);
    sec_req <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, gpic_pkg::ADDR_SEC_CAPTURE, 8'h00);
    chk("capture", 32'h6b, rd);
    apb(1'b0, gpic_pkg::ADDR_LIVE_DATA, 8'h00);
    chk("live data", 32'h6b, rd);
    drv_en <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, gpic_pkg::ADDR_LIVE_DATA, 8'h00);
    chk("live data", 32'h94, rd);
    apb(1'b0, gpic_pkg::ADDR_SEC_CAPTURE, 8'h00);
    chk("capture", 32'h6b, rd);
    aux(8'h81);
    $display("test capture done");
    status_low <= 8'h01;
    apb(1'b1, gpic_pkg::ADDR_MASK_LOW, 8'h01);
    apb(1'b1, gpic_pkg::ADDR_INT_DMA_EN, 8'h83);
    aux(8'h13);
    chk("irq", 32'h1, 32'(irq));
    chk("dma", 32'h3, 32'({dma1_en, dma0_en}));
    aux(8'h93);
    chk("irq", 32'h0, 32'(irq));
    aux(8'h13);
    apb(1'b1, gpic_pkg::ADDR_INT_DMA_EN, 8'h7c);
    aux(8'h16);
    chk("irq", 32'h0, 32'(irq));
    chk("dma", 32'h0, 32'({dma1_en, dma0_en}));
    apb(1'b1, gpic_pkg::ADDR_INT_DMA_EN, 8'h80);
    apb(1'b1, gpic_pkg::ADDR_MASK_LOW, 8'h00);
    status_high <= 6'h20;
    apb(1'b1, gpic_pkg::ADDR_MASK_HIGH, 8'h20);
    aux(8'h16);
    chk("irq", 32'h1, 32'(irq));
    status_high <= 6'h00;
    aux(8'h16);
    chk("irq", 32'h0, 32'(irq));
    $display("test interrupts done");
    ext_atn <= 1'b1;
    tct_req <= 1'b1;
    aux(8'h11);
    apb(1'b0, gpic_pkg::ADDR_FLAGS, 8'h00);
    chk("request control", 32'hc0, rd & 32'hc0);
    ext_atn <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    chk("control taken", 32'h1, 32'(ctrl_active));
    aux(8'h92);
    chk("control released", 32'h0, 32'(ctrl_active));
    apb(1'b0, 10'h3f0, 8'h00);
    chk("unmapped error", 32'h1, 32'(er));
    apb(1'b0, gpic_pkg::ADDR_MASK_HIGH, 8'h00);
    chk("write only error", 32'h1, 32'(er));
    aux(8'h80);
    chk("chip reset", 32'h1, 32'(chip_reset));
    aux(8'h00);
    chk("chip reset", 32'h0, 32'(chip_reset));
    chk("settle", 32'd10, 32'(source_settle_delay));
    $display("test control done");
    test_done();
  end
endmodule : tb_ieee488_interface_control
`default_nettype wire
